// File: rtl/logical_device_config_decode.sv
// Logical device configuration bank and base I/O address decoder.
`timescale 1ns/1ps
// Function
// RULE1: DMA select index 0x74 exists only for floppy and parallel devices.
// RULE2: Index dma_channel_select_second ignores writes and reads zero for every device.
// RULE3: Indexes 0x76-0xA8 and 0xA9-0xDF ignore writes and read zero.
// RULE4: Device is active when activate or power bit is set.
// RULE5: Activate and power bits are one linked bit.
// RULE6: Out-of-range base address stops the device answering host accesses.
// RULE7: Floppy primary interrupt select resets to 0x06, others to zero.
// RULE8: DMA select resets to 0x02 for floppy, 0x04 for device 3.
// RULE9: Floppy primary base resets to 0x03F0.
// RULE10: Floppy and serial bases 0x0100-0x0FF8, 8-aligned; floppy skips offset 6.
// RULE11: Parallel decodes +0..2, +400h..402h; EPP +3..7 only when 8-aligned.
// RULE12: Clock RAM has two index/data banks with their own base ranges.
// RULE13: Keyboard is fixed at addresses 60 and 64, no base registers.
// RULE14: Bank registers are exposed only in configuration state.
// RULE15: Device number register at 0x07 selects the bank for 0x30-0xFF.
// RULE16: Decode compares A11-A0; qualification also requires A15-A12 zero.
// RULE17: A new base acts on the very next host access.
module logical_device_config_decode
  import ldcfg_pkg::*;
#(
  parameter int LD_COUNT = NUM_LD
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic soft_reset,
  input wire logic config_state,
  input wire logic qual16_enable,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_index,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  input wire logic [15:0] io_addr,
  input wire logic io_valid,
  output logic [LD_COUNT-1:0] device_active,
  output logic sel_floppy,
  output logic sel_parallel,
  output logic sel_parallel_epp,
  output logic sel_parallel_ext,
  output logic sel_serial1,
  output logic sel_serial2,
  output logic sel_ram_bank0,
  output logic sel_ram_bank1,
  output logic sel_keyboard,
  output logic [2:0] sel_offset
);
  typedef struct packed {
    logic [2:0] ldn;
    logic [LD_COUNT-1:0] act;
    logic [LD_COUNT-1:0][7:0] pbase_h;
    logic [LD_COUNT-1:0][7:0] pbase_l;
    logic [LD_COUNT-1:0][7:0] sbase_h;
    logic [LD_COUNT-1:0][7:0] sbase_l;
    logic [LD_COUNT-1:0][7:0] irq;
    logic [LD_COUNT-1:0][7:0] dma;
    logic [7:0] rdata;
  } state_t;

  state_t st_reg;
  state_t st_next;
  state_t st_init;

  logic [LD_COUNT-1:0][15:0] pbase;
  logic [LD_COUNT-1:0][15:0] sbase;
  logic ok_floppy;
  logic ok_par4;
  logic ok_par8;
  logic ok_ser1;
  logic ok_ser2;
  logic ok_ram0;
  logic ok_ram1;
  logic hit_floppy;
  logic hit_par_lo;
  logic hit_par_hi;
  logic hit_ser1;
  logic hit_ser2;
  logic hit_ram0;
  logic hit_ram1;
  logic [15:0] ofs_floppy;
  logic [15:0] ofs_par_lo;
  logic [15:0] ofs_par_hi;
  logic [15:0] ofs_ser1;
  logic [15:0] ofs_ser2;
  logic [15:0] ofs_ram0;
  logic [15:0] ofs_ram1;
  logic kbd_data;
  logic kbd_cmd;

  genvar g;
  generate
    for (g = 0; g < LD_COUNT; g++) begin : g_ld
      // The base is read straight from the registers so a write acts at once.
      assign pbase[g] = {st_reg.pbase_h[g], st_reg.pbase_l[g]}; // RULE17
      assign sbase[g] = {st_reg.sbase_h[g], st_reg.sbase_l[g]};
      assign device_active[g] = st_reg.act[g]; // RULE4
    end
  endgenerate

  always_comb begin
    st_init = '0;
    st_init.irq[LD_FLOPPY] = RST_FLOPPY_IRQ; // RULE7
    st_init.dma[LD_FLOPPY] = RST_FLOPPY_DMA; // RULE8
    st_init.dma[LD_PARALLEL] = RST_PARALLEL_DMA; // RULE8
    st_init.pbase_h[LD_FLOPPY] = RST_FLOPPY_BASE_HIGH; // RULE9
    st_init.pbase_l[LD_FLOPPY] = RST_FLOPPY_BASE_LOW; // RULE9
  end

  base_range_check #(.LO(RANGE_LO), .HI(RANGE_HI_8), .ALIGN_MASK(16'h0007)) u_ok_floppy (
    .base(pbase[LD_FLOPPY]),
    .ok(ok_floppy)
  );
  base_range_check #(.LO(RANGE_LO), .HI(RANGE_HI_4), .ALIGN_MASK(16'h0003)) u_ok_par4 (
    .base(pbase[LD_PARALLEL]),
    .ok(ok_par4)
  );
  base_range_check #(.LO(RANGE_LO), .HI(RANGE_HI_8), .ALIGN_MASK(16'h0007)) u_ok_par8 (
    .base(pbase[LD_PARALLEL]),
    .ok(ok_par8)
  );
  base_range_check #(.LO(RANGE_LO), .HI(RANGE_HI_8), .ALIGN_MASK(16'h0007)) u_ok_ser1 (
    .base(pbase[LD_SERIAL1]),
    .ok(ok_ser1)
  );
  base_range_check #(.LO(RANGE_LO), .HI(RANGE_HI_8), .ALIGN_MASK(16'h0007)) u_ok_ser2 (
    .base(pbase[LD_SERIAL2]),
    .ok(ok_ser2)
  );
  base_range_check #(.LO(RANGE_LO), .HI(RANGE_HI_RAM0), .ALIGN_MASK(16'h0000)) u_ok_ram0 (
    .base(pbase[LD_CLOCK_RAM]),
    .ok(ok_ram0)
  );
  base_range_check #(.LO(RANGE_LO), .HI(RANGE_HI_RAM1), .ALIGN_MASK(16'h0000)) u_ok_ram1 (
    .base(sbase[LD_CLOCK_RAM]),
    .ok(ok_ram1)
  );

  io_window_decode #(.SPAN(8)) u_win_floppy (
    .addr(io_addr),
    .base(pbase[LD_FLOPPY]),
    .qual16(qual16_enable),
    .hit(hit_floppy),
    .ofs(ofs_floppy)
  );
  io_window_decode #(.SPAN(8)) u_win_par_lo (
    .addr(io_addr),
    .base(pbase[LD_PARALLEL]),
    .qual16(qual16_enable),
    .hit(hit_par_lo),
    .ofs(ofs_par_lo)
  );
  io_window_decode #(.SPAN(3)) u_win_par_hi (
    .addr(io_addr),
    .base(16'(pbase[LD_PARALLEL] + PAR_HIGH_OFS)),
    .qual16(qual16_enable),
    .hit(hit_par_hi),
    .ofs(ofs_par_hi)
  );
  io_window_decode #(.SPAN(8)) u_win_ser1 (
    .addr(io_addr),
    .base(pbase[LD_SERIAL1]),
    .qual16(qual16_enable),
    .hit(hit_ser1),
    .ofs(ofs_ser1)
  );
  io_window_decode #(.SPAN(8)) u_win_ser2 (
    .addr(io_addr),
    .base(pbase[LD_SERIAL2]),
    .qual16(qual16_enable),
    .hit(hit_ser2),
    .ofs(ofs_ser2)
  );
  io_window_decode #(.SPAN(2)) u_win_ram0 (
    .addr(io_addr),
    .base(pbase[LD_CLOCK_RAM]),
    .qual16(qual16_enable),
    .hit(hit_ram0),
    .ofs(ofs_ram0)
  );
  io_window_decode #(.SPAN(2)) u_win_ram1 (
    .addr(io_addr),
    .base(sbase[LD_CLOCK_RAM]),
    .qual16(qual16_enable),
    .hit(hit_ram1),
    .ofs(ofs_ram1)
  );

  // Keyboard ports are fixed; the low twelve bits are compared, and A15-A12 must also be zero when qual16_enable is set.
  assign kbd_data = (io_addr[11:0] == KBD_DATA_ADDR[11:0])
    && (!qual16_enable || io_addr[15:12] == 4'h0); // RULE13
  assign kbd_cmd = (io_addr[11:0] == KBD_CMD_ADDR[11:0])
    && (!qual16_enable || io_addr[15:12] == 4'h0); // RULE13

  always_comb begin
    sel_floppy = io_valid && st_reg.act[LD_FLOPPY] && ok_floppy && hit_floppy
      && (ofs_floppy[2:0] != FLOPPY_HOLE_OFS); // RULE10
    sel_parallel = io_valid && st_reg.act[LD_PARALLEL] && ok_par4 && hit_par_lo
      && (ofs_par_lo[2:0] <= 3'h2); // RULE11
    sel_parallel_epp = io_valid && st_reg.act[LD_PARALLEL] && ok_par8 && hit_par_lo
      && (ofs_par_lo[2:0] >= 3'h3); // RULE11
    sel_parallel_ext = io_valid && st_reg.act[LD_PARALLEL] && ok_par4 && hit_par_hi; // RULE11
    sel_serial1 = io_valid && st_reg.act[LD_SERIAL1] && ok_ser1 && hit_ser1; // RULE10
    sel_serial2 = io_valid && st_reg.act[LD_SERIAL2] && ok_ser2 && hit_ser2; // RULE10
    sel_ram_bank0 = io_valid && st_reg.act[LD_CLOCK_RAM] && ok_ram0 && hit_ram0; // RULE12
    sel_ram_bank1 = io_valid && st_reg.act[LD_CLOCK_RAM] && ok_ram1 && hit_ram1; // RULE12
    sel_keyboard = io_valid && st_reg.act[LD_KEYBOARD] && (kbd_data || kbd_cmd); // RULE13
    sel_offset = 3'h0;
    if (sel_floppy) begin
      sel_offset = ofs_floppy[2:0];
    end else if (sel_parallel || sel_parallel_epp) begin
      sel_offset = ofs_par_lo[2:0];
    end else if (sel_parallel_ext) begin
      sel_offset = ofs_par_hi[2:0];
    end else if (sel_serial1) begin
      sel_offset = ofs_ser1[2:0];
    end else if (sel_serial2) begin
      sel_offset = ofs_ser2[2:0];
    end else if (sel_ram_bank0) begin
      sel_offset = ofs_ram0[2:0];
    end else if (sel_ram_bank1) begin
      sel_offset = ofs_ram1[2:0];
    end else if (sel_keyboard) begin
      sel_offset = kbd_cmd ? 3'h4 : 3'h0;
    end
  end

  always_comb begin
    logic [2:0] d;
    logic wr;
    logic has_dma;
    logic has_sbase;
    logic has_pbase;
    d = st_reg.ldn;
    st_next = st_reg;
    // Bank registers are hidden outside configuration state.
    wr = cfg_wr && config_state; // RULE14
    has_dma = (d == LD_FLOPPY) || (d == LD_PARALLEL); // RULE1
    has_sbase = (d == LD_CLOCK_RAM);
    has_pbase = (d != LD_KEYBOARD) && (d != 3'h1) && (d != 3'h2);
    if (soft_reset) begin
      st_next = st_init; // RULE8
      st_next.ldn = st_reg.ldn;
    end else if (wr) begin
      if (cfg_index == IDX_LDN) begin
        st_next.ldn = cfg_wdata[2:0]; // RULE15
      end else if (cfg_index == IDX_ACTIVATE) begin
        // One flop serves both the activate and the power bit, so they cannot differ.
        st_next.act[d] = cfg_wdata[ACT_BIT]; // RULE5
      end else if (cfg_index == IDX_PRIMARY_BASE_HIGH && has_pbase) begin
        st_next.pbase_h[d] = cfg_wdata;
      end else if (cfg_index == IDX_PRIMARY_BASE_LOW && has_pbase) begin
        st_next.pbase_l[d] = cfg_wdata;
      end else if (cfg_index == IDX_SECONDARY_BASE_HIGH && has_sbase) begin
        st_next.sbase_h[d] = cfg_wdata;
      end else if (cfg_index == IDX_SECONDARY_BASE_LOW && has_sbase) begin
        st_next.sbase_l[d] = cfg_wdata;
      end else if (cfg_index == IDX_IRQ_PRIMARY) begin
        st_next.irq[d] = cfg_wdata;
      end else if (cfg_index == IDX_DMA_CHANNEL_SELECT && has_dma) begin
        st_next.dma[d] = cfg_wdata; // RULE1
      end
    end
    st_next.rdata = RST_ZERO;
    if (cfg_rd && config_state) begin // RULE14
      if (cfg_index == IDX_LDN) begin
        st_next.rdata = {5'h00, st_reg.ldn};
      end else if (cfg_index == IDX_ACTIVATE) begin
        st_next.rdata = {7'h00, st_reg.act[d]}; // RULE4
      end else if (cfg_index == IDX_PRIMARY_BASE_HIGH && has_pbase) begin
        st_next.rdata = st_reg.pbase_h[d];
      end else if (cfg_index == IDX_PRIMARY_BASE_LOW && has_pbase) begin
        st_next.rdata = st_reg.pbase_l[d];
      end else if (cfg_index == IDX_SECONDARY_BASE_HIGH && has_sbase) begin
        st_next.rdata = st_reg.sbase_h[d];
      end else if (cfg_index == IDX_SECONDARY_BASE_LOW && has_sbase) begin
        st_next.rdata = st_reg.sbase_l[d];
      end else if (cfg_index == IDX_IRQ_PRIMARY) begin
        st_next.rdata = st_reg.irq[d]; // RULE15
      end else if (cfg_index == IDX_DMA_CHANNEL_SELECT && has_dma) begin
        st_next.rdata = st_reg.dma[d];
      end else if (cfg_index == IDX_DMA_CHANNEL_SELECT_SECOND) begin
        st_next.rdata = RST_ZERO; // RULE2
      end else if (cfg_index >= IDX_RSVD_A_LO && cfg_index <= IDX_RSVD_B_HI) begin
        st_next.rdata = RST_ZERO; // RULE3
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{
        ldn: 3'h0,
        act: '0,
        pbase_h: {{(LD_COUNT-1){8'h00}}, RST_FLOPPY_BASE_HIGH},
        pbase_l: {{(LD_COUNT-1){8'h00}}, RST_FLOPPY_BASE_LOW},
        sbase_h: '0,
        sbase_l: '0,
        irq: {{(LD_COUNT-1){8'h00}}, RST_FLOPPY_IRQ},
        dma: {{(LD_COUNT-4){8'h00}}, RST_PARALLEL_DMA, 8'h00, 8'h00, RST_FLOPPY_DMA},
        rdata: 8'h00
      };
    end else begin
      st_reg <= st_next;
    end
  end

  assign cfg_rdata = st_reg.rdata;
endmodule : logical_device_config_decode

// File: rtl/ldcfg_pkg.sv
// Package with indexes, reset values and decode ranges of the logical device configuration bank.
package ldcfg_pkg;
  localparam logic [7:0] IDX_LDN = 8'h07;
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_PRIMARY_BASE_HIGH = 8'h60;
  localparam logic [7:0] IDX_PRIMARY_BASE_LOW = 8'h61;
  localparam logic [7:0] IDX_SECONDARY_BASE_HIGH = 8'h62;
  localparam logic [7:0] IDX_SECONDARY_BASE_LOW = 8'h63;
  localparam logic [7:0] IDX_IRQ_PRIMARY = 8'h70;
  localparam logic [7:0] IDX_DMA_CHANNEL_SELECT = 8'h74;
  localparam logic [7:0] IDX_DMA_CHANNEL_SELECT_SECOND = 8'h75;
  localparam logic [7:0] IDX_RSVD_A_LO = 8'h76;
  localparam logic [7:0] IDX_RSVD_A_HI = 8'ha8;
  localparam logic [7:0] IDX_RSVD_B_LO = 8'ha9;
  localparam logic [7:0] IDX_RSVD_B_HI = 8'hdf;
  localparam logic [7:0] IDX_BANK_LO = 8'h30;
  localparam logic [7:0] IDX_LAST_RESERVED = 8'hff;
  localparam int ACT_BIT = 0;
  localparam int NUM_LD = 8;
  localparam logic [2:0] LD_FLOPPY = 3'h0;
  localparam logic [2:0] LD_PARALLEL = 3'h3;
  localparam logic [2:0] LD_SERIAL1 = 3'h4;
  localparam logic [2:0] LD_SERIAL2 = 3'h5;
  localparam logic [2:0] LD_CLOCK_RAM = 3'h6;
  localparam logic [2:0] LD_KEYBOARD = 3'h7;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_FLOPPY_IRQ = 8'h06;
  localparam logic [7:0] RST_FLOPPY_DMA = 8'h02;
  localparam logic [7:0] RST_PARALLEL_DMA = 8'h04;
  localparam logic [7:0] RST_FLOPPY_BASE_HIGH = 8'h03;
  localparam logic [7:0] RST_FLOPPY_BASE_LOW = 8'hf0;
  localparam logic [15:0] RANGE_LO = 16'h0100;
  localparam logic [15:0] RANGE_HI_8 = 16'h0ff8;
  localparam logic [15:0] RANGE_HI_4 = 16'h0ffc;
  localparam logic [15:0] RANGE_HI_RAM0 = 16'h0ffe;
  localparam logic [15:0] RANGE_HI_RAM1 = 16'h0ffd;
  localparam logic [15:0] PAR_HIGH_OFS = 16'h0400;
  localparam logic [15:0] KBD_DATA_ADDR = 16'h0060;
  localparam logic [15:0] KBD_CMD_ADDR = 16'h0064;
  localparam logic [2:0] FLOPPY_HOLE_OFS = 3'h6;
endpackage : ldcfg_pkg

// File: rtl/base_range_check.sv
// Range and alignment check of one programmed base address.
`timescale 1ns/1ps
module base_range_check
  import ldcfg_pkg::*;
#(
  parameter logic [15:0] LO = 16'h0100,
  parameter logic [15:0] HI = 16'h0ff8,
  parameter logic [15:0] ALIGN_MASK = 16'h0007
) (
  input wire logic [15:0] base,
  output logic ok
);
  assign ok = (base >= LO) && (base <= HI) && ((base & ALIGN_MASK) == 16'h0000); // RULE6
endmodule : base_range_check

// File: rtl/io_window_decode.sv
// Window match of one host address against a base and an offset span.
`timescale 1ns/1ps
module io_window_decode
  import ldcfg_pkg::*;
#(
  parameter int SPAN = 8
) (
  input wire logic [15:0] addr,
  input wire logic [15:0] base,
  input wire logic qual16,
  output logic hit,
  output logic [15:0] ofs
);
  logic [11:0] diff;
  assign diff = addr[11:0] - base[11:0];
  assign ofs = {4'h0, diff};
  assign hit = (addr[11:0] >= base[11:0]) && (diff < 12'(SPAN))
    && (!qual16 || addr[15:12] == 4'h0); // RULE16
endmodule : io_window_decode

// File: sim/ldcfg_host_model.sv
// Host software model driving the configuration index and data ports.
`timescale 1ns/1ps
module ldcfg_host_model (
  input wire logic mclk,
  output logic config_state,
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [7:0] cfg_index,
  output logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata
);
  initial begin
    config_state = 1'b1;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_index = 8'h00;
    cfg_wdata = 8'h00;
  end
  // Idle index and data are inverted so a design that ignores its strobe sees no stale match.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(negedge mclk);
    cfg_index = idx;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge mclk);
    cfg_wr = 1'b0;
    cfg_index = ~idx;
    cfg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    @(negedge mclk);
    cfg_index = idx;
    cfg_rd = 1'b1;
    @(negedge mclk);
    d = cfg_rdata;
    cfg_rd = 1'b0;
    cfg_index = ~idx;
  endtask : rd
  task automatic cfg(input logic v);
    @(negedge mclk);
    config_state = v;
  endtask : cfg
endmodule : ldcfg_host_model

// File: sim/ldcfg_chk_assertions.sv
// Checker of the configuration bank and base decode ports.
`timescale 1ns/1ps
module ldcfg_chk
  import ldcfg_pkg::*;
#(
  parameter int LD_COUNT = NUM_LD
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic soft_reset,
  input wire logic config_state,
  input wire logic qual16_enable,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_index,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic [15:0] io_addr,
  input wire logic io_valid,
  input wire logic [LD_COUNT-1:0] device_active,
  input wire logic sel_floppy,
  input wire logic sel_parallel,
  input wire logic sel_parallel_epp,
  input wire logic sel_keyboard,
  input wire logic [2:0] sel_offset
);
  logic [2:0] ldn_reg;
  // Shadow of the device number, since the design keeps it internal.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ldn_reg <= 3'h0;
    end else if (cfg_wr && config_state && !soft_reset && cfg_index == IDX_LDN) begin
      ldn_reg <= cfg_wdata[2:0];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  rd_idle_a: assert property (!$past(cfg_rd) |-> cfg_rdata == 8'h00) else $error("rdata not idle");
  rsvd_zero_a: assert property (cfg_rd && cfg_index >= 8'h75 && cfg_index <= 8'hdf
    |=> cfg_rdata == 8'h00) else $error("reserved index read nonzero");
  dma_absent_a: assert property (cfg_rd && cfg_index == IDX_DMA_CHANNEL_SELECT
    && ldn_reg != LD_FLOPPY && ldn_reg != LD_PARALLEL |=> cfg_rdata == 8'h00)
    else $error("dma select present");
  no_config_a: assert property (cfg_rd && !config_state |=> cfg_rdata == 8'h00)
    else $error("read outside configuration");
  act_link_a: assert property (cfg_wr && config_state && !soft_reset
    && cfg_index == IDX_ACTIVATE |=> device_active[$past(ldn_reg)] == $past(cfg_wdata[0]))
    else $error("activate write lost");
  flop_gate_a: assert property (sel_floppy |-> io_valid && device_active[0])
    else $error("inactive floppy hit");
  kbd_fixed_a: assert property (sel_keyboard |-> (io_addr[11:0] == 12'h060
    && sel_offset == 3'h0) || (io_addr[11:0] == 12'h064 && sel_offset == 3'h4))
    else $error("keyboard decode wrong");
  qual_high_a: assert property (qual16_enable && (sel_floppy || sel_parallel)
    |-> io_addr[15:12] == 4'h0) else $error("high address not qualified");
  flop_hole_a: assert property (sel_floppy |-> sel_offset != 3'h6
    && sel_offset == io_addr[2:0]) else $error("floppy offset wrong");
  epp_ofs_a: assert property (sel_parallel_epp |-> sel_offset >= 3'h3
    && io_addr[2:0] >= 3'h3) else $error("epp offset wrong");
  soft_clear_a: assert property (soft_reset |=> device_active == '0)
    else $error("soft reset kept activate");
endmodule : ldcfg_chk
bind logical_device_config_decode ldcfg_chk #(.LD_COUNT(LD_COUNT)) u_ldcfg_chk (.*);

// File: sim/tb_logical_device_config_decode.sv
// Testbench of the logical device configuration bank and decoder.
`timescale 1ns/1ps
module tb_logical_device_config_decode;
  logic mclk, rst_n, soft_reset, config_state, qual16_enable, cfg_wr, cfg_rd, io_valid;
  logic [7:0] cfg_index, cfg_wdata, cfg_rdata;
  logic [15:0] io_addr;
  logic [7:0] device_active;
  logic [8:0] sel;
  logic [2:0] sel_offset;
  logic [7:0] rsv [5] = '{8'h75, 8'h76, 8'ha8, 8'ha9, 8'hdf};
  int n_mismatch = 0;
  int n_compared = 0;
  logical_device_config_decode u_logical_device_config_decode (.mclk(mclk), .rst_n(rst_n),
    .soft_reset(soft_reset), .config_state(config_state), .qual16_enable(qual16_enable),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .io_addr(io_addr), .io_valid(io_valid),
    .device_active(device_active), .sel_floppy(sel[8]), .sel_parallel(sel[7]),
    .sel_parallel_epp(sel[6]), .sel_parallel_ext(sel[5]), .sel_serial1(sel[4]),
    .sel_serial2(sel[3]), .sel_ram_bank0(sel[2]), .sel_ram_bank1(sel[1]),
    .sel_keyboard(sel[0]), .sel_offset(sel_offset));
  ldcfg_host_model u_host (.mclk(mclk), .config_state(config_state), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(idx, d);
    check({8'h00, d}, {8'h00, exp});
  endtask : rchk
  // Offset is only meaningful while some window hits.
  task automatic io(input logic [15:0] a, input logic q, input logic [8:0] es,
                    input logic [2:0] eo);
    @(negedge mclk);
    io_addr = a;
    qual16_enable = q;
    #1;
    check({7'h00, sel}, {7'h00, es});
    if (es != 9'h000) check({13'h0000, sel_offset}, {13'h0000, eo});
  endtask : io
  task automatic test_done;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    test_done();
  end
  initial begin
    rst_n = 1'b0;
    soft_reset = 1'b0;
    qual16_enable = 1'b0;
    io_valid = 1'b1;
    io_addr = 16'h0000;
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    rchk(8'h60, 8'h03);
    rchk(8'h61, 8'hf0);
    rchk(8'h70, 8'h06);
    for (int i = 0; i < 5; i++) begin
      u_host.wr(rsv[i], 8'hff);
      rchk(rsv[i], 8'h00);
    end
    rchk(8'h75, 8'h00);
    rchk(8'h74, 8'h02);
    u_host.wr(8'h07, 8'h03);
    rchk(8'h74, 8'h04);
    rchk(8'h70, 8'h00);
    u_host.wr(8'h07, 8'h04);
    rchk(8'h74, 8'h00);
    u_host.wr(8'h07, 8'h00);
    io(16'h03f0, 1'b0, 9'h000, 3'h0);
    u_host.wr(8'h30, 8'h01);
    check({15'h0000, device_active[0]}, 16'h0001);
    rchk(8'h30, 8'h01);
    for (int k = 0; k < 8; k++) begin
      io(16'h03f0 + 16'(k), 1'b0, (k == 6) ? 9'h000 : 9'h100, 3'(k));
    end
    io(16'h13f0, 1'b0, 9'h100, 3'h0);
    io(16'h13f0, 1'b1, 9'h000, 3'h0);
    u_host.wr(8'h60, 8'h00);
    io(16'h00f0, 1'b0, 9'h000, 3'h0);
    u_host.wr(8'h60, 8'h01);
    io(16'h01f0, 1'b0, 9'h100, 3'h0);
    u_host.wr(8'h61, 8'hf4);
    io(16'h01f4, 1'b0, 9'h000, 3'h0);
    u_host.wr(8'h07, 8'h03);
    u_host.wr(8'h30, 8'h01);
    u_host.wr(8'h60, 8'h03);
    u_host.wr(8'h61, 8'h78);
    io(16'h037b, 1'b0, 9'h040, 3'h3);
    io(16'h0379, 1'b0, 9'h080, 3'h1);
    io(16'h077a, 1'b0, 9'h020, 3'h2);
    u_host.wr(8'h61, 8'h7c);
    io(16'h037f, 1'b0, 9'h000, 3'h0);
    u_host.wr(8'h07, 8'h07);
    u_host.wr(8'h30, 8'h01);
    io(16'h0060, 1'b0, 9'h001, 3'h0);
    io(16'h0064, 1'b0, 9'h001, 3'h4);
    io(16'h0061, 1'b0, 9'h000, 3'h0);
    io_valid = 1'b0;
    io(16'h0064, 1'b0, 9'h000, 3'h0);
    io_valid = 1'b1;
    u_host.wr(8'h07, 8'h06);
    u_host.wr(8'h30, 8'h01);
    u_host.wr(8'h60, 8'h01);
    u_host.wr(8'h61, 8'h70);
    u_host.wr(8'h62, 8'h01);
    u_host.wr(8'h63, 8'h72);
    io(16'h0171, 1'b0, 9'h004, 3'h1);
    io(16'h0173, 1'b0, 9'h002, 3'h1);
    u_host.wr(8'h07, 8'h04);
    u_host.wr(8'h30, 8'h01);
    u_host.wr(8'h60, 8'h02);
    u_host.wr(8'h61, 8'hf8);
    io(16'h02fe, 1'b0, 9'h010, 3'h6);
    u_host.wr(8'h07, 8'h05);
    u_host.wr(8'h30, 8'h01);
    u_host.wr(8'h60, 8'h02);
    u_host.wr(8'h61, 8'he8);
    io(16'h02e9, 1'b0, 9'h008, 3'h1);
    io(16'h02f0, 1'b0, 9'h000, 3'h0);
    u_host.cfg(1'b0);
    u_host.wr(8'h30, 8'h00);
    rchk(8'h30, 8'h00);
    check({15'h0000, device_active[5]}, 16'h0001);
    u_host.cfg(1'b1);
    @(negedge mclk);
    soft_reset = 1'b1;
    @(negedge mclk);
    soft_reset = 1'b0;
    check({8'h00, device_active}, 16'h0000);
    u_host.wr(8'h07, 8'h00);
    rchk(8'h61, 8'hf0);
    rchk(8'h74, 8'h02);
    test_done();
  end
endmodule : tb_logical_device_config_decode
